/* File: rtl/flash_link_regs.svh */
// Constants of the serial flash pin front end.
// Notes on behaviour
// RULE1: Link runs in clock mode 0 or 3 only; host idles clock low or high.
// RULE2: Every input bit is sampled at the rising edge of the serial clock.
// RULE3: Every output bit changes at the falling edge of the serial clock.
// RULE4: Serial output is high impedance while device select is high.
// RULE5: Serial input activity is ignored while device select is high.
// RULE6: Operations start on select falling edge and end on select rising edge.
// RULE7: Deselect goes to standby, never to deep power-down.
// RULE8: Deselect during a self-timed cycle enters standby only after it ends.
// RULE9: Write-protect low shields all marked sectors regardless of software protection.
// RULE10: After write-protect goes low, protection register changes are rejected.
// RULE11: Program or erase under write-protect low is discarded; idle after deselect.
// RULE12: Enable-protection and sector-lockdown commands still run under write-protect low.
// RULE13: Write-protect defaults high through a pull-up when left unconnected.
// RULE14: Reset pin low aborts any operation and returns the state machine idle.
// RULE15: Device stays in reset while reset pin is low, resumes when high.
// RULE16: Internal power-on reset; reset pin needs no level at power-up.
// RULE17: Page size selectable 256 or 264 bytes, default 264.
// RULE18: Two independent buffers; data accepted while the array is programmed.
// RULE19: Program and erase cycles are timed internally, no host clocks needed.
// RULE20: Main memory holds 32,768 pages of the selected page size.
// RULE21: After select falls, an 8-bit opcode then address bytes are shifted in.
// RULE22: Opcodes, addresses and data move most significant bit first.
// RULE23: Three address bytes follow the opcode.
// RULE24: Bit counter clears on every select falling edge; partial commands are dropped.
`ifndef FLASH_LINK_REGS_SVH
`define FLASH_LINK_REGS_SVH

`define OPC_BITS        8
`define ADDR_BITS       24
`define HDR_LAST        5'h1F
`define OPC_LAST        5'h07
`define BIT_LAST        3'h7
`define BIT_FIRST       3'h0
`define CNT_ZERO        5'h00
`define PAGE_BITS       15
`define PAGE_COUNT      32768
`define BYTE_BITS       9
`define PAGE264_PG_LSB  9
`define PAGE256_PG_LSB  8
`define PAGE_264_RESET  1'b1
`define SYNC_IDLE_HIGH  1'b1
`define BYTE_ZERO       8'h00

`endif

/* File: rtl/flash_link_pkg.sv */
// Types shared by the serial flash pin front end.
package flash_link_pkg;

   // Framing states of one selected operation.
   typedef enum logic [2:0] {
      st_idle,
      st_opcode,
      st_addr,
      st_data,
      st_discard
   } frame_e;

   // Decoded command header handed to the memory core.
   typedef struct packed {
      logic [7:0]  opcode;
      logic [14:0] page;
      logic [8:0]  byte_addr;
      logic [23:0] raw_addr;
   } cmd_s;

   // Opcode class supplied by the core's decoder.
   typedef struct packed {
      logic modify;      // Program or erase of the array.
      logic prot_write;  // Changes the sector protection register.
      logic exempt;      // Enable-protection or sector-lockdown.
   } op_class_s;

   // Two-stage synchronisers for the pins, plus one history stage.
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic       sck_d;
      logic       sel_d;
   } sync_s;

   // Whole state of the front end.
   typedef struct packed {
      sync_s       sy;
      frame_e      state;
      logic [4:0]  hdr_cnt;
      logic [2:0]  bit_cnt;
      logic [31:0] hdr;
      logic [7:0]  rx_sh;
      logic [7:0]  tx_sh;
      logic        so;
      logic        so_oe;
      logic        cmd_valid;
      cmd_s        cmd;
      logic        rx_valid;
      logic [7:0]  rx_byte;
      logic        tx_take;
      logic        cmd_reject;
      logic        standby;
      logic        page_264;
      logic        selected;
   } state_s;

endpackage : flash_link_pkg

/* File: rtl/flash_link.sv */
// Pin-level serial front end of a serial flash: framing, edges, tri-state, protection gate.
`timescale 1ns/1ps
`include "flash_link_regs.svh"

module flash_link (
   // Clock and power-on reset.
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   // Device pins from the host.
   input  wire logic                      sel_n_pin,
   input  wire logic                      sck_pin,
   input  wire logic                      si_pin,
   input  wire logic                      wp_n_pin,
   input  wire logic                      rst_n_pin,
   // Serial output pin.
   output logic                           so_out,
   output logic                           so_oe,
   // Configuration and core status.
   input  wire logic                      cfg_page_256,
   input  wire logic                      core_busy,
   input  wire flash_link_pkg::op_class_s op_class,
   // Command and data towards the core.
   output logic                           cmd_valid,
   output flash_link_pkg::cmd_s           cmd,
   output logic                           cmd_reject,
   output logic                           rx_valid,
   output logic [7:0]                     rx_byte,
   // Output data from the core.
   input  wire logic                      tx_en,
   input  wire logic [7:0]                tx_data,
   output logic                           tx_take,
   // Front end status.
   output logic                           standby,
   output logic                           page_264,
   output logic                           selected
);

   // Index of each pin in the synchroniser vectors.
   localparam int unsigned P_SEL = 0;
   localparam int unsigned P_SCK = 1;
   localparam int unsigned P_SI  = 2;
   localparam int unsigned P_WP  = 3;
   localparam int unsigned P_RST = 4;

   flash_link_pkg::state_s r_r;
   flash_link_pkg::state_s r_nxt;

   // Synchronised pin levels; only the second stage is read by logic.
   logic sel_n_s;
   logic sck_s;
   logic si_s;
   logic wp_n_s;
   logic rst_n_s;
   logic sck_rise;
   logic sck_fall;
   logic sel_fall;
   logic sel_rise;
   logic block_cmd;
   logic [31:0] hdr_in;

   // Pin levels after the two-stage synchroniser.
   assign sel_n_s = r_r.sy.s2[P_SEL];
   assign sck_s   = r_r.sy.s2[P_SCK];
   assign si_s    = r_r.sy.s2[P_SI];
   assign wp_n_s  = r_r.sy.s2[P_WP];
   assign rst_n_s = r_r.sy.s2[P_RST];

   // Edges of the serial clock and of device select; mode 0 and 3 both work
   // because only edges inside the selected window are used.
   assign sck_rise = sck_s & ~r_r.sy.sck_d;  // see RULE1
   assign sck_fall = ~sck_s & r_r.sy.sck_d;
   assign sel_fall = ~sel_n_s & r_r.sy.sel_d;
   assign sel_rise = sel_n_s & ~r_r.sy.sel_d;

   // Header with the bit sampled at this rising edge shifted in, MSB first.
   assign hdr_in = {r_r.hdr[30:0], si_s};  // see RULE22

   // Write-protect gate: modifying commands are blocked, exempt ones pass.
   assign block_cmd = ~wp_n_s & (op_class.modify | op_class.prot_write) & ~op_class.exempt;  // see RULE9

   // Next-state logic of the whole front end.
   always_comb begin
      r_nxt = r_r;
      // Two-flop synchronisers; the first stage feeds only the second.
      r_nxt.sy.s1    = {rst_n_pin, wp_n_pin, si_pin, sck_pin, sel_n_pin};
      r_nxt.sy.s2    = r_r.sy.s1;
      r_nxt.sy.sck_d = sck_s;
      r_nxt.sy.sel_d = sel_n_s;
      // Strobes last one cycle.
      r_nxt.cmd_valid  = 1'b0;
      r_nxt.rx_valid   = 1'b0;
      r_nxt.tx_take    = 1'b0;
      r_nxt.cmd_reject = 1'b0;
      r_nxt.selected   = ~sel_n_s;
      // Page size follows the configuration; reset value is the 264 byte page.
      r_nxt.page_264   = ~cfg_page_256;  // see RULE17
      // Output is driven only while selected.
      r_nxt.so_oe      = ~sel_n_s;  // see RULE4

      if (~rst_n_s) begin
         // Reset pin held low: abort and hold idle until it rises again.
         r_nxt.state   = flash_link_pkg::st_idle;  // see RULE14
         r_nxt.hdr_cnt = `CNT_ZERO;  // see RULE15
         r_nxt.bit_cnt = `BIT_FIRST;
         r_nxt.so_oe   = 1'b0;
         r_nxt.standby = 1'b0;
         r_nxt.selected = 1'b0;  // see RULE14
      end else if (sel_n_s) begin
         // Deselected: SI is ignored; standby once any self-timed cycle ends.
         r_nxt.state   = flash_link_pkg::st_idle;  // see RULE5
         r_nxt.standby = ~core_busy;  // see RULE7
         if (core_busy) begin
            r_nxt.standby = 1'b0;  // see RULE8 RULE19
         end
      end else if (sel_fall) begin
         // A new operation begins; any partial command is thrown away.
         r_nxt.state   = flash_link_pkg::st_opcode;  // see RULE6
         r_nxt.hdr_cnt = `CNT_ZERO;  // see RULE24
         r_nxt.bit_cnt = `BIT_FIRST;
         r_nxt.standby = 1'b0;
      end else begin
         r_nxt.standby = 1'b0;
         unique case (r_r.state)
            flash_link_pkg::st_idle: begin
               // Select was already low at reset release: wait for a fresh fall.
               r_nxt.state = flash_link_pkg::st_idle;
            end
            flash_link_pkg::st_opcode: begin
               if (sck_rise) begin
                  r_nxt.hdr     = hdr_in;  // see RULE2
                  r_nxt.hdr_cnt = r_r.hdr_cnt + 5'h01;
                  if (r_r.hdr_cnt == `OPC_LAST) begin
                     r_nxt.state = flash_link_pkg::st_addr;  // see RULE21
                  end
               end
            end
            flash_link_pkg::st_addr: begin
               if (sck_rise) begin
                  r_nxt.hdr     = hdr_in;  // see RULE2
                  r_nxt.hdr_cnt = r_r.hdr_cnt + 5'h01;
                  if (r_r.hdr_cnt == `HDR_LAST) begin
                     // Opcode plus three address bytes are in.
                     r_nxt.cmd.opcode   = hdr_in[31:24];  // see RULE23
                     r_nxt.cmd.raw_addr = hdr_in[23:0];
                     if (r_r.page_264) begin
                        r_nxt.cmd.page      = hdr_in[`PAGE264_PG_LSB +: `PAGE_BITS];  // see RULE20
                        r_nxt.cmd.byte_addr = hdr_in[`BYTE_BITS-1:0];
                     end else begin
                        r_nxt.cmd.page      = hdr_in[`PAGE256_PG_LSB +: `PAGE_BITS];  // see RULE20
                        r_nxt.cmd.byte_addr = {1'b0, hdr_in[7:0]};
                     end
                     r_nxt.bit_cnt = `BIT_FIRST;
                     if (block_cmd) begin
                        // Protected: no action until the host deselects.
                        r_nxt.state      = flash_link_pkg::st_discard;  // see RULE11
                        r_nxt.cmd_reject = 1'b1;  // see RULE10
                     end else begin
                        r_nxt.state     = flash_link_pkg::st_data;  // see RULE12
                        r_nxt.cmd_valid = 1'b1;
                     end
                  end
               end
            end
            flash_link_pkg::st_data: begin
               if (sck_rise) begin
                  // Data bytes stream to the core even while it programs.
                  r_nxt.rx_sh   = {r_r.rx_sh[6:0], si_s};  // see RULE18
                  r_nxt.bit_cnt = r_r.bit_cnt + 3'h1;
                  if (r_r.bit_cnt == `BIT_LAST) begin
                     r_nxt.rx_byte  = {r_r.rx_sh[6:0], si_s};  // see RULE22
                     r_nxt.rx_valid = 1'b1;
                  end
               end
               if (sck_fall && tx_en) begin
                  // Output bit changes on the falling edge, MSB first.
                  if (r_r.bit_cnt == `BIT_FIRST) begin
                     r_nxt.so      = tx_data[7];  // see RULE3
                     r_nxt.tx_sh   = {tx_data[6:0], 1'b0};
                     r_nxt.tx_take = 1'b1;
                  end else begin
                     r_nxt.so    = r_r.tx_sh[7];  // see RULE3
                     r_nxt.tx_sh = {r_r.tx_sh[6:0], 1'b0};
                  end
               end
            end
            flash_link_pkg::st_discard: begin
               // Stay here, ignoring the clock, until select rises.
               r_nxt.state = flash_link_pkg::st_discard;  // see RULE11
            end
         endcase
      end

      // The rising select edge is seen above through sel_n_s; it ends the frame.
      if (sel_rise) begin
         r_nxt.state = flash_link_pkg::st_idle;  // see RULE6
      end
   end

   // State register; reset_n is the internal power-on reset.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_r          <= '0;  // see RULE16
         r_r.sy.s1    <= {5{`SYNC_IDLE_HIGH}};  // see RULE13
         r_r.sy.s2    <= {5{`SYNC_IDLE_HIGH}};
         r_r.sy.sel_d <= `SYNC_IDLE_HIGH;
         r_r.sy.sck_d <= `SYNC_IDLE_HIGH;
         r_r.state    <= flash_link_pkg::st_idle;
         r_r.page_264 <= `PAGE_264_RESET;  // see RULE17
         r_r.rx_byte  <= `BYTE_ZERO;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Outputs straight from the state register.
   assign so_out     = r_r.so;
   assign so_oe      = r_r.so_oe;
   assign cmd_valid  = r_r.cmd_valid;
   assign cmd        = r_r.cmd;
   assign cmd_reject = r_r.cmd_reject;
   assign rx_valid   = r_r.rx_valid;
   assign rx_byte    = r_r.rx_byte;
   assign tx_take    = r_r.tx_take;
   assign standby    = r_r.standby;
   assign page_264   = r_r.page_264;
   assign selected   = r_r.selected;

endmodule : flash_link

/* File: testbench/flash_link_props.sv */
// Checker of the serial flash front end port behaviour.
`timescale 1ns/1ps
module flash_link_props (
   // Clock and reset.
   input wire logic                      clk,
   input wire logic                      reset_n,
   // Pins and core inputs.
   input wire logic                      sel_n_pin,
   input wire logic                      wp_n_pin,
   input wire logic                      rst_n_pin,
   input wire logic                      core_busy,
   input wire flash_link_pkg::op_class_s op_class,
   // Outputs.
   input wire logic                      so_oe,
   input wire logic                      cmd_valid,
   input wire flash_link_pkg::cmd_s      cmd,
   input wire logic                      cmd_reject,
   input wire logic                      rx_valid,
   input wire logic                      tx_take,
   input wire logic                      standby,
   input wire logic                      page_264,
   input wire logic                      selected
);
   // All checks run on the system clock and rest during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Port relations over time.
   oe_off_deselect_a: assert property (sel_n_pin [*5] |-> !so_oe) else $error("output driven while deselected");
   si_ignored_a: assert property (sel_n_pin [*5] |-> !rx_valid && !cmd_valid) else $error("input taken while deselected");
   cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid) else $error("command strobe too long");
   one_verdict_a: assert property (!(cmd_valid && cmd_reject)) else $error("command both taken and refused");
   reject_cause_a: assert property (cmd_reject |-> !$past(wp_n_pin, 4) && !op_class.exempt)
      else $error("refusal without protect");
   protect_gate_a: assert property (cmd_valid && !$past(wp_n_pin, 4) |-> op_class.exempt || !(op_class.modify || op_class.prot_write))
      else $error("modify passed under protect");
   split_264_a: assert property (cmd_valid && page_264 |=> cmd.page == cmd.raw_addr[23:9] && cmd.byte_addr == cmd.raw_addr[8:0])
      else $error("264 split wrong");
   split_256_a: assert property (cmd_valid && !page_264 |=> cmd.page == cmd.raw_addr[22:8] && cmd.byte_addr == {1'b0, cmd.raw_addr[7:0]})
      else $error("256 split wrong");
   pin_reset_a: assert property (!rst_n_pin [*7] |-> !so_oe && !standby && !cmd_valid && !selected)
      else $error("reset pin not obeyed");
   busy_standby_a: assert property (core_busy |=> !standby) else $error("standby while busy");
   take_selected_a: assert property (tx_take |-> selected) else $error("output taken while idle");
   // Main scenarios.
   cmd_c: cover property (cmd_valid);
   rej_c: cover property (cmd_reject);
   take_c: cover property (tx_take);
endmodule : flash_link_props

/* File: testbench/flash_host.sv */
// Host model that drives the serial link pins in clock mode 0 or 3.
`timescale 1ns/1ps
module flash_host (
   // Pins towards the device.
   output logic      sel_n,
   output logic      sck,
   output logic      si,
   input  wire logic so_out,
   input  wire logic so_oe
);
   // Clock level between frames: low for mode 0, high for mode 3.
   logic idle_high = 1'b0;
   // Idle pins: deselected and clock low.
   initial begin
      sel_n = 1'b1;
      sck   = 1'b0;
      si    = 1'b0;
   end
   // Sends n bits of v, top bit first, and samples the output at each rise.
   task automatic shift(input int n, input logic [31:0] v, output logic [31:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--) begin
         if (sck) begin
            sck = 1'b0;
         end
         si = v[i];
         #62.5;
         sck = 1'b1;
         r = {r[30:0], so_oe ? so_out : 1'bx};
         #62.5;
      end
      if (!idle_high) begin
         sck = 1'b0;
      end
   endtask : shift
   // Selects the idle clock level, which picks clock mode 0 or 3.
   task automatic set_mode(input logic high);
      idle_high = high;
      sck       = high;
   endtask : set_mode
   // A frame opens on a select fall and closes on a select rise.
   task automatic open_frame();
      sel_n = 1'b0;
      #100;
   endtask : open_frame
   task automatic close_frame();
      #100;
      sel_n = 1'b1;
      // The input line moves after deselect; the device must not take it.
      si    = ~si;
      #100;
   endtask : close_frame
endmodule : flash_host

/* File: testbench/flash_link_tb.sv */
// Testbench of the serial flash pin front end.
`timescale 1ns/1ps
module flash_link_tb;
   logic clk = 1'b0;
   logic reset_n, rst_n_pin, wp_n_pin, cfg_page_256, core_busy, tx_en, sel_n, sck, si;
   logic so_out, so_oe, cmd_valid, cmd_reject, rx_valid, tx_take, standby, page_264, selected;
   logic [7:0] tx_data, rx_byte;
   logic [31:0] rd;
   logic [23:0] a;
   logic [3:0] row;
   flash_link_pkg::op_class_s op_class;
   flash_link_pkg::cmd_s cmd;
   int num_errors = 0, compares = 0, n_cmd = 0, n_rej = 0, n_rx = 0, n_take = 0, cycles = 0, ec, er, erx;
   always #5 clk = ~clk;
   flash_host i_flash_host (.sel_n(sel_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe));
   flash_link i_flash_link (.clk(clk), .reset_n(reset_n), .sel_n_pin(sel_n), .sck_pin(sck), .si_pin(si),
      .wp_n_pin(wp_n_pin), .rst_n_pin(rst_n_pin), .so_out(so_out), .so_oe(so_oe), .cfg_page_256(cfg_page_256),
      .core_busy(core_busy), .op_class(op_class), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_reject(cmd_reject),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_en(tx_en), .tx_data(tx_data), .tx_take(tx_take),
      .standby(standby), .page_264(page_264), .selected(selected));
   // Counts strobes and cuts a hang short.
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
      if (cmd_reject === 1'b1) n_rej <= n_rej + 1;
      if (rx_valid === 1'b1) n_rx <= n_rx + 1;
      if (tx_take === 1'b1) n_take <= n_take + 1;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         num_errors++;
         stop_test();
      end
   end
   // Compares one value and reports a mismatch.
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Sends a full frame: header, one data byte, deselect.
   task automatic frame(input logic [31:0] h, input logic [7:0] d);
      i_flash_host.open_frame();
      i_flash_host.shift(32, h, rd);
      i_flash_host.shift(8, {24'h00_0000, d}, rd);
      i_flash_host.close_frame();
   endtask : frame
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // Main sequence.
   initial begin
      {reset_n, cfg_page_256, core_busy, tx_en} = 4'h0;
      {rst_n_pin, wp_n_pin} = 2'b11;
      op_class = 3'h0;
      tx_data = 8'hA5;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (5) @(negedge clk);
      check("page_264", 1, page_264);
      for (int p = 0; p < 2; p++) begin
         cfg_page_256 = p[0];
         a = 24'h12_3456 + p;
         repeat (3) @(negedge clk);
         frame({8'h5A, a}, 8'hC3 + p);
         check("cmd count", p + 1, n_cmd);
         check("opcode", 8'h5A, cmd.opcode);
         check("raw addr", a, cmd.raw_addr);
         check("page", p ? a[22:8] : a[23:9], cmd.page);
         check("byte", p ? {1'b0, a[7:0]} : a[8:0], cmd.byte_addr);
         check("rx_byte", 8'hC3 + p, rx_byte);
         check("standby", 1, standby);
      end
      $display("Test header and page split done");
      {ec, er, erx} = {32'd2, 32'd0, 32'd2};
      for (int k = 0; k < 5; k++) begin
         row = (k == 4) ? 4'hC : (k == 3) ? 4'h0 : (k == 2) ? 4'h5 : (k == 1) ? 4'h2 : 4'h4;
         wp_n_pin = row[3];
         op_class = row[2:0];
         repeat (6) @(negedge clk);
         frame(32'h8100_0000, 8'h11);
         if (!row[3] && (row[2] || row[1]) && !row[0]) er++;
         else begin
            ec++;
            erx++;
         end
         check("reject count", er, n_rej);
         check("cmd count", ec, n_cmd);
         check("rx count", erx, n_rx);
      end
      $display("Test write protect done");
      i_flash_host.open_frame();
      i_flash_host.shift(5, 32'h0000_001F, rd);
      i_flash_host.close_frame();
      @(negedge clk);
      frame(32'h3300_0200, 8'h00);
      check("cmd count", ec + 1, n_cmd);
      check("opcode", 8'h33, cmd.opcode);
      $display("Test partial frame done");
      tx_en = 1'b1;
      i_flash_host.open_frame();
      i_flash_host.shift(32, 32'h0B00_0000, rd);
      i_flash_host.shift(8, 32'h0000_0000, rd);
      check("so data", 8'hA5, rd[7:0]);
      check("tx_take", 1, n_take);
      check("so_oe on", 1, so_oe);
      check("selected", 1, selected);
      i_flash_host.close_frame();
      check("so_oe off", 0, so_oe);
      $display("Test serial output done");
      i_flash_host.set_mode(1'b1);
      repeat (3) @(negedge clk);
      i_flash_host.open_frame();
      i_flash_host.shift(32, 32'h0B12_3456, rd);
      i_flash_host.shift(8, 32'h0000_0000, rd);
      check("so data mode 3", 8'hA5, rd[7:0]);
      i_flash_host.close_frame();
      check("cmd count mode 3", ec + 3, n_cmd);
      check("raw addr mode 3", 24'h12_3456, cmd.raw_addr);
      check("tx_take mode 3", 3, n_take);
      i_flash_host.set_mode(1'b0);
      @(negedge clk);
      $display("Test clock mode 3 done");
      core_busy = 1'b1;
      i_flash_host.open_frame();
      i_flash_host.shift(16, 32'h0000_4400, rd);
      rst_n_pin = 1'b0;
      repeat (10) @(negedge clk);
      check("so_oe in reset", 0, so_oe);
      check("selected in reset", 0, selected);
      rst_n_pin = 1'b1;
      i_flash_host.shift(16, 32'h0000_0000, rd);
      i_flash_host.close_frame();
      check("cmd count", ec + 3, n_cmd);
      check("standby busy", 0, standby);
      core_busy = 1'b0;
      repeat (3) @(negedge clk);
      check("standby idle", 1, standby);
      frame(32'h4400_0000, 8'h00);
      check("cmd count", ec + 4, n_cmd);
      $display("Test reset pin done");
      stop_test();
   end
endmodule : flash_link_tb
bind flash_link flash_link_props i_flash_link_props (.clk, .reset_n, .sel_n_pin, .wp_n_pin, .rst_n_pin, .core_busy,
   .op_class, .so_oe, .cmd_valid, .cmd, .cmd_reject, .rx_valid, .tx_take, .standby, .page_264, .selected);
